// ==== pfswc_flash_model.sv ====
// Behavioural program flash array with row latches
`timescale 1ns/1ns
module pfswc_flash_model
  import pfswc_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              slow,
  input  wire logic [ADDR_W-1:0] fa_addr,
  input  wire logic              fa_cfg_space,
  input  wire logic              fa_read,
  input  wire logic              fa_latch_we,
  input  wire logic [WORD_W-1:0] fa_latch_data,
  input  wire logic              fa_prog_start,
  input  wire logic              fa_erase_start,
  output logic [WORD_W-1:0]      fa_rdata,
  output logic                   fa_done
);
  logic [WORD_W-1:0] mem [2][1<<ADDR_W];
  logic [WORD_W-1:0] lat [32];
  int                busy = 0;
  wire  [ADDR_W-1:0] row = {fa_addr[ADDR_W-1:ROW_BITS], 5'h00};
  // Outside a read the bus shows the inverse, never the stored word
  assign fa_rdata = fa_read ? mem[fa_cfg_space][fa_addr] : ~mem[fa_cfg_space][fa_addr];
  initial begin
    foreach (mem[s, a]) mem[s][a] = 14'h3FFF;
    foreach (lat[i]) lat[i] = 14'h3FFF;
    fa_done = 1'b0;
  end
  always @(posedge hclk) begin
    fa_done <= (busy == 1);
    if (busy > 0) busy <= busy - 1;
    if (fa_latch_we) lat[fa_addr[4:0]] <= fa_latch_data;
    if (fa_erase_start) begin
      for (int i = 0; i < 32; i++) mem[fa_cfg_space][row + i] <= 14'h3FFF;
      busy <= slow ? 20 : 2;
    end
    if (fa_prog_start) begin
      for (int i = 0; i < 32; i++) mem[fa_cfg_space][row + i] <= lat[i];
      busy <= slow ? 20 : 2;
    end
  end
endmodule // pfswc_flash_model

// ==== pfswc_pkg.sv ====
// Shared constants and types for the program flash self-write controller
package pfswc_pkg;

  // Register byte offsets on the bus
  localparam logic [4:0] OFS_CONTROL   = 5'h00;
  localparam logic [4:0] OFS_UNLOCK    = 5'h04;
  localparam logic [4:0] OFS_ADDR_LOW  = 5'h08;
  localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
  localparam logic [4:0] OFS_DATA_LOW  = 5'h10;
  localparam logic [4:0] OFS_DATA_HIGH = 5'h14;

  // Control register bit positions
  localparam int BIT_READ_START  = 0;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_PE_ENABLE   = 2;
  localparam int BIT_ERASE_SEL   = 4;
  localparam int BIT_LATCH_ONLY  = 5;
  localparam int BIT_CFG_SPACE   = 6;
  localparam int BIT_UNIMPL_ONE  = 7;

  // Word and address geometry
  localparam int WORD_W   = 14;
  localparam int ADDR_W   = 13;
  localparam int ROW_BITS = 5;
  localparam int BYTE_W   = 8;
  localparam int HI_DATA_W = WORD_W - BYTE_W;
  localparam int HI_ADDR_W = ADDR_W - BYTE_W;

  // Unlock key values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Timing
  localparam int CLK_FREQ_KHZ  = 25000;
  localparam int PWRT_TIME_MS  = 64;
  localparam int PWRT_CYCLES   = PWRT_TIME_MS * CLK_FREQ_KHZ;
  localparam int SETUP_CYCLES  = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LATCH = 3'b010,
    ST_START = 3'b011,
    ST_WAIT  = 3'b100
  } pfswc_state_e;

  typedef enum logic [1:0] {
    UK_IDLE  = 2'b00,
    UK_FIRST = 2'b01,
    UK_READY = 2'b10
  } pfswc_unlock_e;

endpackage : pfswc_pkg

// ==== pfswc_pwrt.sv ====
// Power-up timer that holds off flash writes after reset
`timescale 1ns/1ns
module pfswc_pwrt
  import pfswc_pkg::*;
#(
  parameter int CYCLES = PWRT_CYCLES
)
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  pfswc_sub_if.pwrt  sub
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } pfswc_pwrt_s;

  pfswc_pwrt_s s_q;
  pfswc_pwrt_s s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.done) begin
      if (s_q.cnt == LAST) begin
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{cnt: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sub.pwrt_done = s_q.done;
endmodule // pfswc_pwrt

// ==== pfswc_sub_if.sv ====
// Signals between the controller core and its unlock and power-up helpers
`timescale 1ns/1ns
interface pfswc_sub_if;
  logic       reg_access;
  logic       key_write;
  logic [7:0] key_data;
  logic       unlocked;
  logic       pwrt_done;

  modport ctrl   (output reg_access, output key_write, output key_data,
                  input unlocked, input pwrt_done);
  modport unlock (input reg_access, input key_write, input key_data, output unlocked);
  modport pwrt   (output pwrt_done);
endinterface : pfswc_sub_if

// ==== pfswc_top.sv ====
// Program flash self-read and self-write controller with AHB-Lite registers
`timescale 1ns/1ns
module pfswc_top
  import pfswc_pkg::*;
#(
  parameter int PWRT_CNT = PWRT_CYCLES
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output logic [ADDR_W-1:0]      fa_addr,
  output logic                   fa_cfg_space,
  output logic                   fa_read,
  input  wire logic [WORD_W-1:0] fa_rdata,
  output logic                   fa_latch_we,
  output logic [WORD_W-1:0]      fa_latch_data,
  output logic                   fa_prog_start,
  output logic                   fa_erase_start,
  input  wire logic              fa_done,
  output logic                   cpu_force_nop,
  output logic                   cpu_stall,
  input  wire logic              sp_mod_req,
  input  wire logic [ADDR_W-1:0] sp_mod_addr,
  input  wire logic [ADDR_W-1:0] wp_limit,
  output logic                   sp_mod_grant,
  output logic                   sp_mod_reject
);
  localparam int SETUP_W = 2;
  localparam logic [SETUP_W-1:0] SETUP_LAST = SETUP_W'(SETUP_CYCLES - 1);

  typedef struct packed {
    logic                  cfg_space;
    logic                  latch_only;
    logic                  erase_sel;
    logic                  pe_enable;
    logic                  write_start;
    logic                  read_start;
    logic [ADDR_W-1:0]     addr;
    logic [WORD_W-1:0]     data;
    pfswc_state_e          st;
    logic [SETUP_W-1:0]    setup_cnt;
    logic                  dph_valid;
    logic                  dph_write;
    logic [4:0]            dph_ofs;
    logic [31:0]           rdata;
    logic                  sp_grant;
    logic                  sp_reject;
  } pfswc_top_s;

  pfswc_top_s  s_q;
  pfswc_top_s  s_d;
  pfswc_sub_if sub ();

  pfswc_unlock u_unlock (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sub     (sub.unlock)
  );

  pfswc_pwrt #(
    .CYCLES (PWRT_CNT)
  ) u_pwrt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sub     (sub.pwrt)
  );

  // Register read image of a given state
  function automatic logic [31:0] read_mux(input logic [4:0] ofs, input pfswc_top_s s);
    logic [31:0] r;
    r = '0;
    case (ofs)
      OFS_CONTROL: begin
        r[BIT_UNIMPL_ONE]  = 1'b1;
        r[BIT_CFG_SPACE]   = s.cfg_space;
        r[BIT_LATCH_ONLY]  = s.latch_only;
        r[BIT_ERASE_SEL]   = s.erase_sel;
        r[BIT_PE_ENABLE]   = s.pe_enable;
        r[BIT_WRITE_START] = s.write_start;
        r[BIT_READ_START]  = s.read_start;
      end
      OFS_UNLOCK:    r = '0;
      OFS_ADDR_LOW:  r[BYTE_W-1:0] = s.addr[BYTE_W-1:0];
      OFS_ADDR_HIGH: r[HI_ADDR_W-1:0] = s.addr[ADDR_W-1:BYTE_W];
      OFS_DATA_LOW:  r[BYTE_W-1:0] = s.data[BYTE_W-1:0];
      OFS_DATA_HIGH: r[HI_DATA_W-1:0] = s.data[WORD_W-1:BYTE_W];
      default:       r = '0;
    endcase
    return r;
  endfunction

  logic        addr_phase;
  logic        wr_ok;
  logic        rd_set;
  logic [31:0] wd;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wd         = hwdata;
  assign rd_set     = s_q.dph_valid && s_q.dph_write && (s_q.dph_ofs == OFS_CONTROL) && wd[BIT_READ_START];

  // Data-phase side effects toward the helpers
  assign sub.reg_access = s_q.dph_valid;
  assign sub.key_write  = s_q.dph_valid && s_q.dph_write && (s_q.dph_ofs == OFS_UNLOCK);
  assign sub.key_data   = wd[BYTE_W-1:0];

  // Start is only honoured with enable, unlock and expired timer
  assign wr_ok = s_q.pe_enable && sub.unlocked && sub.pwrt_done && (s_q.st == ST_IDLE);

  always_comb begin
    s_d = s_q;
    s_d.sp_grant  = 1'b0;
    s_d.sp_reject = 1'b0;

    // Register writes in the data phase
    if (s_q.dph_valid && s_q.dph_write) begin
      case (s_q.dph_ofs)
        OFS_CONTROL: begin
          if (s_q.st == ST_IDLE) begin
            s_d.cfg_space  = wd[BIT_CFG_SPACE];
            s_d.latch_only = wd[BIT_LATCH_ONLY];
            s_d.erase_sel  = wd[BIT_ERASE_SEL];
            s_d.pe_enable  = wd[BIT_PE_ENABLE];
          end
          if (wd[BIT_READ_START]) begin
            s_d.read_start = 1'b1;
          end
          if (wd[BIT_WRITE_START] && wr_ok) begin
            s_d.write_start = 1'b1;
            s_d.st          = ST_SETUP;
            s_d.setup_cnt   = '0;
          end
        end
        OFS_UNLOCK: begin
          // Watched only, nothing stored
          s_d.rdata = s_d.rdata;
        end
        OFS_ADDR_LOW:  s_d.addr[BYTE_W-1:0] = wd[BYTE_W-1:0];
        OFS_ADDR_HIGH: s_d.addr[ADDR_W-1:BYTE_W] = wd[HI_ADDR_W-1:0];
        OFS_DATA_LOW:  s_d.data[BYTE_W-1:0] = wd[BYTE_W-1:0];
        OFS_DATA_HIGH: s_d.data[WORD_W-1:BYTE_W] = wd[HI_DATA_W-1:0];
        default: begin
          s_d.rdata = s_d.rdata;
        end
      endcase
    end

    // Read completes in one cycle; hardware wins over a data write
    // A new read command in the clearing cycle wins
    if (s_q.read_start) begin
      s_d.data       = fa_rdata;
      s_d.read_start = rd_set;
    end

    // Write and erase sequencer
    case (s_q.st)
      ST_IDLE: begin
        s_d.setup_cnt = '0;
      end
      ST_SETUP: begin
        if (s_q.setup_cnt == SETUP_LAST) begin
          s_d.st = s_q.erase_sel ? ST_START : ST_LATCH;
        end else begin
          s_d.setup_cnt = s_q.setup_cnt + SETUP_W'(1);
        end
      end
      ST_LATCH: begin
        if (s_q.latch_only) begin
          s_d.st          = ST_IDLE;
          s_d.write_start = 1'b0;
        end else begin
          s_d.st = ST_START;
        end
      end
      ST_START: begin
        s_d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (fa_done) begin
          s_d.st          = ST_IDLE;
          s_d.write_start = 1'b0;
          s_d.erase_sel   = 1'b0;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Serial port modifications stay out of the protected region
    if (sp_mod_req) begin
      if (sp_mod_addr < wp_limit) begin
        s_d.sp_reject = 1'b1;
      end else begin
        s_d.sp_grant = 1'b1;
      end
    end

    // Bus address phase capture
    if (hready) begin
      s_d.dph_valid = addr_phase;
      s_d.dph_write = hwrite;
      s_d.dph_ofs   = haddr[4:0];
      if (addr_phase && (haddr[31:5] != '0)) begin
        s_d.dph_ofs = 5'h1F;
      end
    end
    if (addr_phase && !hwrite) begin
      s_d.rdata = read_mux(s_d.dph_ofs, s_d);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{cfg_space: 1'b0, latch_only: 1'b0, erase_sel: 1'b0,
               pe_enable: 1'b0, write_start: 1'b0, read_start: 1'b0,
               addr: '0, data: '0, st: ST_IDLE, setup_cnt: '0,
               dph_valid: 1'b0, dph_write: 1'b0, dph_ofs: '0, rdata: '0,
               sp_grant: 1'b0, sp_reject: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;

  // Row operations ignore the low address bits
  always_comb begin
    fa_addr = s_q.addr;
    if (s_q.st == ST_START || s_q.st == ST_WAIT) begin
      fa_addr[ROW_BITS-1:0] = '0;
    end
  end

  assign fa_cfg_space   = s_q.cfg_space;
  assign fa_read        = s_q.read_start;
  assign fa_latch_we    = (s_q.st == ST_LATCH);
  assign fa_latch_data  = s_q.data;
  assign fa_prog_start  = (s_q.st == ST_START) && !s_q.erase_sel;
  assign fa_erase_start = (s_q.st == ST_START) && s_q.erase_sel;
  assign cpu_force_nop  = (s_q.st == ST_SETUP);
  assign cpu_stall      = (s_q.st == ST_LATCH) || (s_q.st == ST_START) || (s_q.st == ST_WAIT);
  assign sp_mod_grant   = s_q.sp_grant;
  assign sp_mod_reject  = s_q.sp_reject;
endmodule // pfswc_top

// ==== pfswc_top_checker.sv ====
// Port-level assertions for the flash self-write controller
`timescale 1ns/1ns
module pfswc_top_checker
  import pfswc_pkg::*;
#(
  parameter int PWRT_CNT = PWRT_CYCLES
)
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic [ADDR_W-1:0] fa_addr,
  input wire logic              fa_read,
  input wire logic              fa_latch_we,
  input wire logic              fa_prog_start,
  input wire logic              fa_erase_start,
  input wire logic              fa_done,
  input wire logic              cpu_force_nop,
  input wire logic              cpu_stall,
  input wire logic              sp_mod_req,
  input wire logic [ADDR_W-1:0] sp_mod_addr,
  input wire logic [ADDR_W-1:0] wp_limit,
  input wire logic              sp_mod_grant,
  input wire logic              sp_mod_reject
);
  int  up_q;
  wire key_rd = hsel && htrans[1] && hready && !hwrite && haddr == 32'(OFS_UNLOCK);
  wire any_op = fa_latch_we || fa_prog_start || fa_erase_start || cpu_force_nop;
  logic ctl_wr_q;
  // Data phase of a control write carrying a read command
  wire  rd_cmd = ctl_wr_q && hwdata[BIT_READ_START];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctl_wr_q <= 1'b0;
    else ctl_wr_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'(OFS_CONTROL);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_q <= 0;
    else if (up_q < PWRT_CNT) up_q <= up_q + 1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pwrt_hold: assert property (up_q < PWRT_CNT |-> !any_op)
    else $error("flash activity during power-up hold");
  a_key_zero: assert property (key_rd |=> hrdata == 32'h0)
    else $error("unlock register read not zero");
  a_nop_two: assert property ($rose(cpu_force_nop) |-> cpu_force_nop [*2] ##1 !cpu_force_nop)
    else $error("setup no-op window not two cycles");
  a_setup_then_op: assert property ($fell(cpu_force_nop) |-> fa_latch_we || fa_erase_start)
    else $error("no latch or erase after setup");
  a_prog_after_latch: assert property (fa_prog_start |-> $past(fa_latch_we))
    else $error("program without latch load");
  a_erase_row: assert property (fa_erase_start |-> fa_addr[4:0] == 5'h00)
    else $error("erase address not row aligned");
  a_stall_end: assert property (fa_done && cpu_stall |=> !cpu_stall)
    else $error("stall held after done");
  a_read_once: assert property (fa_read && !rd_cmd |=> !fa_read)
    else $error("read strobe longer than one cycle");
  a_read_start: assert property (rd_cmd |=> fa_read)
    else $error("read command did not start a read");
  a_sp_reject: assert property (sp_mod_req && sp_mod_addr < wp_limit |=> sp_mod_reject && !sp_mod_grant)
    else $error("protected serial change not rejected");
  a_sp_grant: assert property (sp_mod_req && sp_mod_addr >= wp_limit |=> sp_mod_grant && !sp_mod_reject)
    else $error("open serial change not granted");
  c_erase: cover property (fa_erase_start);
  c_prog: cover property (fa_prog_start);
  c_reject: cover property (sp_mod_reject);
endmodule // pfswc_top_checker
bind pfswc_top pfswc_top_checker #(.PWRT_CNT(PWRT_CNT)) pfswc_top_checker_inst (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .fa_addr, .fa_read, .fa_latch_we, .fa_prog_start, .fa_erase_start,
  .fa_done, .cpu_force_nop, .cpu_stall, .sp_mod_req, .sp_mod_addr, .wp_limit, .sp_mod_grant, .sp_mod_reject);

// ==== pfswc_top_tb.sv ====
// Self-checking bench for the flash self-write controller
`timescale 1ns/1ns
module pfswc_top_tb
  import pfswc_pkg::*;
;
  localparam int PW = 40;
  logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, slow, sp_mod_req;
  logic              fa_cfg_space, fa_read, fa_latch_we, fa_prog_start, fa_erase_start, fa_done;
  logic              cpu_force_nop, cpu_stall, sp_mod_grant, sp_mod_reject;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr, hwdata, hrdata, r;
  logic [ADDR_W-1:0] fa_addr, sp_mod_addr, wp_limit;
  logic [WORD_W-1:0] fa_rdata, fa_latch_data;
  int                n_fail = 0, compares = 0, cyc = 0, n_latch = 0, n_prog = 0, n_erase = 0, n_nop = 0;
  assign hready = hreadyout;
  pfswc_top #(.PWRT_CNT(PW)) pfswc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .fa_addr, .fa_cfg_space, .fa_read, .fa_rdata, .fa_latch_we,
    .fa_latch_data, .fa_prog_start, .fa_erase_start, .fa_done, .cpu_force_nop, .cpu_stall, .sp_mod_req,
    .sp_mod_addr, .wp_limit, .sp_mod_grant, .sp_mod_reject);
  pfswc_flash_model pfswc_flash_model_inst (.hclk, .slow, .fa_addr, .fa_cfg_space, .fa_read, .fa_latch_we,
    .fa_latch_data, .fa_prog_start, .fa_erase_start, .fa_rdata, .fa_done);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    n_latch += fa_latch_we;
    n_prog += fa_prog_start;
    n_erase += fa_erase_start;
    n_nop += cpu_force_nop;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // Single AHB transfer; read data lands in r
  task automatic xf(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    compares++;
    if (hresp !== 1'b0) begin
      n_fail++;
      $display("unexpected at %0t: error response", $time);
    end
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    xf(1'b0, a, 8'h00);
    chk(r, e);
  endtask
  task automatic op(input logic [7:0] c);
    xf(1'b1, OFS_CONTROL, c);
    xf(1'b1, OFS_UNLOCK, KEY_FIRST);
    xf(1'b1, OFS_UNLOCK, KEY_SECOND);
    xf(1'b1, OFS_CONTROL, c | 8'h02);
  endtask
  task automatic wait_idle;
    repeat (60) begin
      xf(1'b0, OFS_CONTROL, 8'h00);
      if (r[BIT_WRITE_START] === 1'b0) break;
    end
  endtask
  task automatic rdw(input logic [7:0] a, input logic [7:0] c, input logic [13:0] e);
    xf(1'b1, OFS_ADDR_LOW, a);
    xf(1'b1, OFS_CONTROL, c);
    rc(OFS_DATA_LOW, {24'h0, e[7:0]});
    rc(OFS_DATA_HIGH, {26'h0, e[13:8]});
  endtask
  task automatic sp(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    sp_mod_req <= 1'b1;
    sp_mod_addr <= a;
    @(posedge hclk);
    sp_mod_req <= 1'b0;
    @(posedge hclk);
    chk({30'h0, sp_mod_grant, sp_mod_reject}, e);
  endtask
  task results;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    slow = 1'b0;
    sp_mod_req = 1'b0;
    sp_mod_addr = 13'h0000;
    wp_limit = 13'h0100;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc(OFS_CONTROL, 32'h80);
    rc(OFS_UNLOCK, 32'h0);
    rc(32'h20, 32'h0);
    op(8'h04);
    rc(OFS_CONTROL, 32'h84);
    repeat (PW) @(posedge hclk);
    chk(n_nop, 0);
    $display("test power-up done");
    xf(1'b1, OFS_ADDR_HIGH, 8'hFF);
    rc(OFS_ADDR_HIGH, 32'h1F);
    xf(1'b1, OFS_DATA_HIGH, 8'hFF);
    rc(OFS_DATA_HIGH, 32'h3F);
    $display("test register widths done");
    op(8'h00);
    rc(OFS_CONTROL, 32'h80);
    xf(1'b1, OFS_CONTROL, 8'h04);
    xf(1'b1, OFS_UNLOCK, KEY_FIRST);
    xf(1'b0, OFS_ADDR_LOW, 8'h00);
    xf(1'b1, OFS_UNLOCK, KEY_SECOND);
    xf(1'b1, OFS_CONTROL, 8'h06);
    rc(OFS_CONTROL, 32'h84);
    xf(1'b1, OFS_UNLOCK, KEY_SECOND);
    xf(1'b1, OFS_UNLOCK, KEY_FIRST);
    rc(OFS_UNLOCK, 32'h0);
    xf(1'b1, OFS_CONTROL, 8'h06);
    rc(OFS_CONTROL, 32'h84);
    chk(n_nop, 0);
    $display("test refused starts done");
    slow <= 1'b1;
    xf(1'b1, OFS_ADDR_HIGH, 8'h01);
    xf(1'b1, OFS_ADDR_LOW, 8'h25);
    op(8'h14);
    xf(1'b1, OFS_CONTROL, 8'h00);
    rc(OFS_CONTROL, 32'h96);
    wait_idle();
    chk(r, 32'h84);
    chk(n_erase, 1);
    chk(n_nop, 2);
    slow <= 1'b0;
    $display("test erase done");
    xf(1'b1, OFS_ADDR_LOW, 8'h20);
    xf(1'b1, OFS_DATA_HIGH, 8'h15);
    xf(1'b1, OFS_DATA_LOW, 8'hA5);
    op(8'h24);
    wait_idle();
    chk(n_latch + n_prog * 2, 1);
    xf(1'b1, OFS_ADDR_LOW, 8'h21);
    xf(1'b1, OFS_DATA_HIGH, 8'h2C);
    xf(1'b1, OFS_DATA_LOW, 8'h3C);
    op(8'h04);
    wait_idle();
    chk(n_latch * 2 + n_prog, 5);
    rdw(8'h20, 8'h05, 14'h15A5);
    rdw(8'h21, 8'h05, 14'h2C3C);
    rdw(8'h22, 8'h05, 14'h3FFF);
    rdw(8'h21, 8'h45, 14'h3FFF);
    rc(OFS_CONTROL, 32'hC4);
    $display("test program and read done");
    sp(13'h00FF, 32'h1);
    sp(13'h0100, 32'h2);
    $display("test serial port done");
    results();
  end
endmodule // pfswc_top_tb

// ==== pfswc_unlock.sv ====
// Unlock key sequence detector
`timescale 1ns/1ns
module pfswc_unlock
  import pfswc_pkg::*;
(
  input  wire logic    hclk,
  input  wire logic    hresetn,
  pfswc_sub_if.unlock  sub
);
  typedef struct packed {
    pfswc_unlock_e st;
  } pfswc_uk_s;

  pfswc_uk_s s_q;
  pfswc_uk_s s_d;

  always_comb begin
    s_d = s_q;
    if (sub.reg_access) begin
      if (sub.key_write && sub.key_data == KEY_FIRST) begin
        s_d.st = UK_FIRST;
      end else if (sub.key_write && sub.key_data == KEY_SECOND && s_q.st == UK_FIRST) begin
        s_d.st = UK_READY;
      end else begin
        s_d.st = UK_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: UK_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  assign sub.unlocked = (s_q.st == UK_READY);
endmodule // pfswc_unlock
